// ==== verilog/converter_ctrl_pkg.sv ====
/*
 * Constants and types shared by the dual-channel converter output control.
 * Assumes a 200 MHz core clock; every cycle count here is counted in that clock
 * or in cycles of the converter clock that arrives as a plain level input.
 */
package converter_ctrl_pkg;

	localparam int WORD_W              = 10;
	localparam int PIPE_DEPTH          = 3;
	localparam int TRIM_CYCLES         = 34;
	localparam int TRIM_CONVERSIONS    = 32;
	localparam int TRIM_FIRST_ACC      = TRIM_CYCLES - TRIM_CONVERSIONS;
	localparam int AVG_SHIFT           = 5;
	localparam int ACC_W               = WORD_W + AVG_SHIFT;
	localparam int OFFSET_W            = WORD_W + 1;
	localparam int TRIM_CNT_W          = 6;

	localparam logic [WORD_W-1:0]   MID_CODE     = 10'h200;
	localparam logic [WORD_W-1:0]   MAX_CODE     = 10'h3ff;
	localparam logic [WORD_W-1:0]   BUS_RESET    = 10'h000;
	localparam logic [OFFSET_W-1:0] OFFSET_RESET = 11'h000;
	localparam logic [ACC_W-1:0]    ACC_RESET    = 15'h0000;

	// time in its own unit, cycle counts derived and rounded down (longest times)
	localparam int CORE_CLK_PERIOD_PS      = 5000;
	localparam int STANDBY_RECOVERY_NS     = 800;
	localparam int STANDBY_RECOVERY_CYCLES = (STANDBY_RECOVERY_NS * 1000) / CORE_CLK_PERIOD_PS;
	localparam int SLEEP_RECOVERY_MS       = 1;
	localparam int SLEEP_RECOVERY_CYCLES   = (SLEEP_RECOVERY_MS * 1000000000) / CORE_CLK_PERIOD_PS;
	localparam int WAKE_CNT_W              = 18;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_STANDBY,
		MODE_SLEEP,
		MODE_WAKE
	} power_mode_t;

endpackage

// ==== verilog/dual_converter_output_control.sv ====
/*
 * Digital side of a dual 10-bit sampling converter: sampling on the converter
 * clock, offset trim, code format, parallel or multiplexed output buses, the
 * channel-phase strobe and standby/power-down recovery.
 * Assumes every input, the converter clock among them, is synchronous to
 * core_clk and that the converter clock is much slower than core_clk.
 */
// Function
// - both channels capture their inputs on the converter clock falling edge.
// - layout select high gives both channels on their own buses at once.
// - layout select low interleaves both on first bus; second bus held low.
// - trim trigger rising edge starts a 34-cycle offset correction per channel; edges outside normal conversion are ignored.
// - correction averages 32 conversions per channel into an offset estimate.
// - after correction each channel subtracts its estimate from later results.
// - format select low gives offset binary, high gives two's complement.
// - format may change anytime; one or two words after it may be wrong.
// - standby and deep-sleep both low means normal conversion.
// - standby alone enters standby; valid again within 800 ns after release.
// - deep-sleep high powers down; recovery under 1 ms after release.
// - both requests high behaves as power-down; deep-sleep wins.
// - bus bit 0 is the result LSB, bit 9 the MSB.
// - parallel data updates just after the clock rise; capture samples after.
// - multiplexed: strobe high carries first channel, low carries second.
// - multiplexed strobe rises on switch to first, falls on switch to second.
// - parallel strobe rises whenever new data appears on the buses.
// - latency 2.5 cycles parallel, and for first-channel multiplexed words.
// - multiplexed second-channel word appears 3 cycles after its sample.
`timescale 1ns/10ps

module dual_converter_output_control
	import converter_ctrl_pkg::*;
#(
	parameter int STANDBY_WAKE_CYCLES = STANDBY_RECOVERY_CYCLES,
	parameter int SLEEP_WAKE_CYCLES   = SLEEP_RECOVERY_CYCLES
) (
	input  wire logic              core_clk,           // core clock, 200 MHz
	input  wire logic              rst,                // synchronous reset, active high
	input  wire logic              convClk,            // shared converter clock level
	input  wire logic [WORD_W-1:0] firstSample,        // first channel quantizer code
	input  wire logic [WORD_W-1:0] secondSample,       // second channel quantizer code
	input  wire logic              busLayoutSelect,    // 1 parallel, 0 multiplexed
	input  wire logic              offsetTrimTrigger,  // rising edge starts offset trim, only in run mode
	input  wire logic              codeFormatSelect,   // 0 offset binary, 1 two's complement
	input  wire logic              standbyRequest,     // standby request
	input  wire logic              deepSleepRequest,   // power-down request
	output logic      [WORD_W-1:0] firstChannelBus,    // first output bus
	output logic      [WORD_W-1:0] secondChannelBus,   // second output bus
	output logic                   channelPhaseStrobe, // channel phase / data valid
	output logic                   trimBusy,           // offset trim in progress
	output logic                   converting          // normal conversion active
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// subtract a signed offset and clamp to the code range
	function automatic logic [WORD_W-1:0] applyOffset(input logic [WORD_W-1:0] code,
	                                                 input logic [OFFSET_W-1:0] off);
		logic signed [OFFSET_W+1:0] diff;
		diff = $signed({3'b000, code}) - $signed({{2{off[OFFSET_W-1]}}, off});
		if (diff < 0)
			applyOffset = BUS_RESET;
		else if (diff > $signed({3'b000, MAX_CODE}))
			applyOffset = MAX_CODE;
		else
			applyOffset = diff[WORD_W-1:0];
	endfunction

	// two's complement differs from offset binary only in the msb
	function automatic logic [WORD_W-1:0] formatCode(input logic [WORD_W-1:0] code,
	                                                input logic twos);
		formatCode = {code[WORD_W-1] ^ twos, code[WORD_W-2:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// edges of the converter clock and the trim trigger

	logic convClkPrev_reg;
	logic trimTrigPrev_reg;
	wire  convFall  = convClkPrev_reg & ~convClk;
	wire  convRise  = ~convClkPrev_reg & convClk;
	wire  trimStart = offsetTrimTrigger & ~trimTrigPrev_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			convClkPrev_reg  <= 1'b0;
			trimTrigPrev_reg <= 1'b0;
		end else begin
			convClkPrev_reg  <= convClk;
			trimTrigPrev_reg <= offsetTrimTrigger;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power modes

	power_mode_t             mode_reg;
	power_mode_t             mode_next;
	logic [WAKE_CNT_W-1:0]   wakeCount_reg;
	logic [WAKE_CNT_W-1:0]   wakeCount_next;

	localparam logic [WAKE_CNT_W-1:0] STANDBY_WAKE = WAKE_CNT_W'(STANDBY_WAKE_CYCLES);
	localparam logic [WAKE_CNT_W-1:0] SLEEP_WAKE   = WAKE_CNT_W'(SLEEP_WAKE_CYCLES);

	wire running = (mode_reg == MODE_RUN);

	always_comb begin
		mode_next      = mode_reg;
		wakeCount_next = wakeCount_reg;
		if (deepSleepRequest) begin
			mode_next = MODE_SLEEP;
		end else if (standbyRequest) begin
			if (mode_reg != MODE_SLEEP)
				mode_next = MODE_STANDBY;
			else begin
				// leaving power-down into standby still owes the long recovery
				mode_next      = MODE_STANDBY;
				wakeCount_next = SLEEP_WAKE;
			end
		end else begin
			unique case (mode_reg)
				MODE_RUN: begin
					mode_next = MODE_RUN;
				end
				MODE_STANDBY: begin
					mode_next = MODE_WAKE;
					if (wakeCount_reg < STANDBY_WAKE)
						wakeCount_next = STANDBY_WAKE;
				end
				MODE_SLEEP: begin
					mode_next      = MODE_WAKE;
					wakeCount_next = SLEEP_WAKE;
				end
				MODE_WAKE: begin
					if (wakeCount_reg <= WAKE_CNT_W'(1))
						mode_next = MODE_RUN;
					wakeCount_next = wakeCount_reg - WAKE_CNT_W'(1);
				end
			endcase
		end
		if (mode_next == MODE_RUN)
			wakeCount_next = '0;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode_reg      <= MODE_RUN;
			wakeCount_reg <= '0;
		end else begin
			mode_reg      <= mode_next;
			wakeCount_reg <= wakeCount_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sample pipeline, advanced on each falling converter clock edge

	logic [WORD_W-1:0]     pipeFirst_reg  [PIPE_DEPTH];
	logic [WORD_W-1:0]     pipeSecond_reg [PIPE_DEPTH];
	logic [PIPE_DEPTH-1:0] pipeValid_reg;

	// a word only reaches the buses once a full pipeline of fresh samples exists
	always_ff @(posedge core_clk) begin
		if (rst || !running) begin
			pipeValid_reg <= '0;
		end else if (convFall) begin
			pipeValid_reg <= {pipeValid_reg[PIPE_DEPTH-2:0], 1'b1};
		end
	end

	always_ff @(posedge core_clk) begin
		if (convFall) begin
			pipeFirst_reg[0]  <= firstSample;
			pipeSecond_reg[0] <= secondSample;
			for (int i = 1; i < PIPE_DEPTH; i++) begin
				pipeFirst_reg[i]  <= pipeFirst_reg[i-1];
				pipeSecond_reg[i] <= pipeSecond_reg[i-1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// offset trim: 34 falling edges, the last 32 accumulated

	logic [TRIM_CNT_W-1:0] trimCount_reg;
	logic                  trimBusy_reg;
	logic [ACC_W-1:0]      accFirst_reg;
	logic [ACC_W-1:0]      accSecond_reg;
	logic [OFFSET_W-1:0]   offFirst_reg;
	logic [OFFSET_W-1:0]   offSecond_reg;

	wire trimAcc  = trimBusy_reg & convFall & (trimCount_reg >= TRIM_CNT_W'(TRIM_FIRST_ACC));
	wire trimLast = trimBusy_reg & convFall & (trimCount_reg == TRIM_CNT_W'(TRIM_CYCLES - 1));

	wire [ACC_W-1:0] sumFirst  = accFirst_reg + ACC_W'(firstSample);
	wire [ACC_W-1:0] sumSecond = accSecond_reg + ACC_W'(secondSample);
	wire [OFFSET_W-1:0] avgFirst  = {1'b0, sumFirst[ACC_W-1:AVG_SHIFT]} - {1'b0, MID_CODE};
	wire [OFFSET_W-1:0] avgSecond = {1'b0, sumSecond[ACC_W-1:AVG_SHIFT]} - {1'b0, MID_CODE};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			trimBusy_reg  <= 1'b0;
			trimCount_reg <= '0;
			accFirst_reg  <= ACC_RESET;
			accSecond_reg <= ACC_RESET;
			offFirst_reg  <= OFFSET_RESET;
			offSecond_reg <= OFFSET_RESET;
		end else if (trimStart && running) begin
			trimBusy_reg  <= 1'b1;
			trimCount_reg <= '0;
			accFirst_reg  <= ACC_RESET;
			accSecond_reg <= ACC_RESET;
		end else if (trimLast) begin
			trimBusy_reg  <= 1'b0;
			offFirst_reg  <= avgFirst;
			offSecond_reg <= avgSecond;
		end else if (trimBusy_reg && convFall) begin
			trimCount_reg <= trimCount_reg + TRIM_CNT_W'(1);
			if (trimAcc) begin
				accFirst_reg  <= sumFirst;
				accSecond_reg <= sumSecond;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output words

	// format is taken once per pair so both words of a pair share a coding
	wire               outValid  = running & pipeValid_reg[PIPE_DEPTH-1];
	wire [WORD_W-1:0]  wordFirst = formatCode(applyOffset(pipeFirst_reg[PIPE_DEPTH-1],
	                                          offFirst_reg), codeFormatSelect);
	wire [WORD_W-1:0]  wordSecond = formatCode(applyOffset(pipeSecond_reg[PIPE_DEPTH-1],
	                                           offSecond_reg), codeFormatSelect);

	logic [WORD_W-1:0] firstBus_reg;
	logic [WORD_W-1:0] secondBus_reg;
	logic [WORD_W-1:0] secondHold_reg;
	logic              strobe_reg;
	logic              layout_reg;

	always_ff @(posedge core_clk) begin
		if (rst || !outValid) begin
			firstBus_reg   <= BUS_RESET;
			secondBus_reg  <= BUS_RESET;
			secondHold_reg <= BUS_RESET;
			strobe_reg     <= 1'b0;
			layout_reg     <= 1'b1;
		end else if (convRise) begin
			// the third rise after a sampling fall sits 2.5 cycles later
			layout_reg     <= busLayoutSelect;
			firstBus_reg   <= wordFirst;
			secondBus_reg  <= busLayoutSelect ? wordSecond : BUS_RESET;
			secondHold_reg <= wordSecond;
			strobe_reg     <= 1'b1;
		end else if (convFall) begin
			strobe_reg <= 1'b0;
			if (!layout_reg)
				firstBus_reg <= secondHold_reg;
		end
	end

	logic converting_reg;

	always_ff @(posedge core_clk) begin
		if (rst)
			converting_reg <= 1'b0;
		else
			converting_reg <= running;
	end

	assign firstChannelBus    = firstBus_reg;
	assign secondChannelBus   = secondBus_reg;
	assign channelPhaseStrobe = strobe_reg;
	assign trimBusy           = trimBusy_reg;
	assign converting         = converting_reg;

endmodule

// ==== test/converter_output_monitor.sv ====
/* checker for the converter output control, ports only.
   assumes convClk holds each level for 4 core cycles, as the bench makes it. */
`timescale 1ns/10ps
module converter_output_monitor
	import converter_ctrl_pkg::*;
#(
	parameter int STANDBY_WAKE_CYCLES = 20,
	parameter int SLEEP_WAKE_CYCLES   = 50
) (
	input wire logic              core_clk,           // clock
	input wire logic              rst,                // reset
	input wire logic              convClk,            // converter clock
	input wire logic [WORD_W-1:0] firstSample,        // first input
	input wire logic [WORD_W-1:0] secondSample,       // second input
	input wire logic              busLayoutSelect,    // layout
	input wire logic              offsetTrimTrigger,  // trim start
	input wire logic              codeFormatSelect,   // format
	input wire logic              standbyRequest,     // standby
	input wire logic              deepSleepRequest,   // power-down
	input wire logic [WORD_W-1:0] firstChannelBus,    // first bus
	input wire logic [WORD_W-1:0] secondChannelBus,   // second bus
	input wire logic              channelPhaseStrobe, // strobe
	input wire logic              trimBusy,           // trim busy
	input wire logic              converting          // running
);
	localparam int SB_MAX = STANDBY_WAKE_CYCLES + 4;
	localparam int SL_MAX = SLEEP_WAKE_CYCLES + 4;
	logic [5:0] fallCnt;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// falls counted in the same sample the trim logic sees them
	always_ff @(posedge core_clk) begin
		if (rst || !trimBusy)
			fallCnt <= 6'h00;
		else if ($fell(convClk))
			fallCnt <= fallCnt + 6'h01;
	end
	////////////////////////////////////////////////////////////////////////////////
	a_trim_falls: assert property ($fell(trimBusy) |-> fallCnt == TRIM_CYCLES)
		else $error("trim length wrong");
	a_mux_second_low: assert property ((!busLayoutSelect)[*8] ##1 (!busLayoutSelect)[*8]
		|-> secondChannelBus == 10'h000)
		else $error("second bus not low in multiplexed mode");
	a_strobe_rise: assert property ($rose(channelPhaseStrobe) && converting
		|-> convClk && !$past(convClk, 3))
		else $error("strobe rose away from clock rise");
	a_strobe_fall: assert property ($fell(channelPhaseStrobe) && converting
		|-> !convClk && $past(convClk, 3))
		else $error("strobe fell away from clock fall");
	a_bus_on_edge: assert property (converting && !$stable(firstChannelBus)
		|-> $past(convClk) != $past(convClk, 2) || $past(convClk, 2) != $past(convClk, 3))
		else $error("bus changed mid phase");
	a_sleep_stops: assert property (deepSleepRequest |-> ##2 !converting)
		else $error("running in power-down");
	a_standby_stops: assert property (standbyRequest |-> ##2 !converting)
		else $error("running in standby");
	a_standby_wake: assert property ($fell(standbyRequest) && !deepSleepRequest
		&& !$past(deepSleepRequest)
		|-> ##[1:SB_MAX] (converting || standbyRequest || deepSleepRequest))
		else $error("standby recovery too slow");
	a_sleep_wake: assert property ($fell(deepSleepRequest) && !standbyRequest
		|-> ##[1:SL_MAX] (converting || standbyRequest || deepSleepRequest))
		else $error("power-down recovery too slow");
	c_trim: cover property ($fell(trimBusy));
	c_mux: cover property ($rose(channelPhaseStrobe) && !busLayoutSelect);
	c_wake: cover property ($rose(converting));
endmodule
bind dual_converter_output_control converter_output_monitor #(
	.STANDBY_WAKE_CYCLES(STANDBY_WAKE_CYCLES), .SLEEP_WAKE_CYCLES(SLEEP_WAKE_CYCLES)) u_mon (
	.core_clk, .rst, .convClk, .firstSample, .secondSample, .busLayoutSelect,
	.offsetTrimTrigger, .codeFormatSelect, .standbyRequest, .deepSleepRequest,
	.firstChannelBus, .secondChannelBus, .channelPhaseStrobe, .trimBusy, .converting);

// ==== test/sample_capture_model.sv ====
/* capture logic on the far side of the output buses.
   assumes strobe and buses are registered on the same core clock edge. */
`timescale 1ns/10ps
module sample_capture_model
	import converter_ctrl_pkg::*;
(
	input wire logic              core_clk,           // clock
	input wire logic              busLayoutSelect,    // layout in use
	input wire logic [WORD_W-1:0] firstChannelBus,    // first bus
	input wire logic [WORD_W-1:0] secondChannelBus,   // second bus
	input wire logic              channelPhaseStrobe, // strobe
	output logic      [WORD_W-1:0] capFirst,          // last first word
	output logic      [WORD_W-1:0] capSecond,         // last second word
	output int                     pairCount          // pairs taken
);
	logic strobePrev = 1'b0;
	initial pairCount = 0;
	always @(posedge core_clk) begin
		strobePrev <= channelPhaseStrobe;
		if (channelPhaseStrobe && !strobePrev) begin
			capFirst <= firstChannelBus;
			if (busLayoutSelect) begin
				capSecond <= secondChannelBus;
				pairCount <= pairCount + 1;
			end
		end
		if (!channelPhaseStrobe && strobePrev && !busLayoutSelect) begin
			capSecond <= firstChannelBus;
			pairCount <= pairCount + 1;
		end
	end
endmodule

// ==== test/test_dual_converter_output_control.sv ====
/* self-checking bench: parallel, multiplexed, trim and power scenarios.
   assumes shortened wake counts of 20 and 50 core cycles. */
`timescale 1ns/10ps
module test_dual_converter_output_control
	import converter_ctrl_pkg::*;
;
	logic              core_clk = 1'b0, rst = 1'b1, convClk = 1'b0;
	logic [WORD_W-1:0] firstSample = MID_CODE, secondSample = MID_CODE;
	logic              busLayoutSelect = 1'b1, offsetTrimTrigger = 1'b0;
	logic              codeFormatSelect = 1'b0, standbyRequest = 1'b0, deepSleepRequest = 1'b0;
	logic [WORD_W-1:0] firstChannelBus, secondChannelBus, capFirst, capSecond;
	logic              channelPhaseStrobe, trimBusy, converting;
	int                pairCount, fail_count = 0, compares = 0;
	dual_converter_output_control #(.STANDBY_WAKE_CYCLES(20), .SLEEP_WAKE_CYCLES(50))
		u_dual_converter_output_control (.core_clk, .rst, .convClk, .firstSample,
		.secondSample, .busLayoutSelect, .offsetTrimTrigger, .codeFormatSelect,
		.standbyRequest, .deepSleepRequest, .firstChannelBus, .secondChannelBus,
		.channelPhaseStrobe, .trimBusy, .converting);
	sample_capture_model u_sample_capture_model (.core_clk, .busLayoutSelect,
		.firstChannelBus, .secondChannelBus, .channelPhaseStrobe, .capFirst, .capSecond,
		.pairCount);
	initial forever #2.5 core_clk = ~core_clk;
	initial forever begin
		repeat (4) @(posedge core_clk);
		#1 convClk = ~convClk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [WORD_W-1:0] got, exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s got %h not %h", $time, what, got, exp);
		end
	endtask
	task automatic drive(input logic [WORD_W-1:0] f, s, input logic lay, fmt);
		@(posedge core_clk);
		#1 firstSample = f;
		secondSample = s;
		busLayoutSelect = lay;
		codeFormatSelect = fmt;
	endtask
	// five pairs flush the sampling pipeline and any words spoilt by a format change
	task automatic pairs();
		int start;
		start = pairCount;
		for (int i = 0; i < 400 && pairCount < start + 5; i++)
			@(posedge core_clk);
		#1 check({9'h000, pairCount >= start + 5}, 10'h001, "pairs");
	endtask
	task automatic wake_time(output int n);
		n = 0;
		while (converting !== 1'b1 && n < 200) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic parallel_test();
		drive(10'h2a5, 10'h15a, 1'b1, 1'b0);
		pairs();
		check(capFirst, 10'h2a5, "parallel first");
		check(capSecond, 10'h15a, "parallel second");
		drive(10'h2a5, 10'h15a, 1'b1, 1'b1);
		pairs();
		check(capFirst, 10'h0a5, "twos first");
		check(capSecond, 10'h35a, "twos second");
	endtask
	task automatic mux_test();
		drive(10'h3c1, 10'h03e, 1'b0, 1'b0);
		pairs();
		check(capFirst, 10'h3c1, "mux first");
		check(capSecond, 10'h03e, "mux second");
		check(secondChannelBus, 10'h000, "mux second bus");
	endtask
	task automatic trim_test();
		int n;
		drive(10'h205, 10'h205, 1'b1, 1'b0);
		offsetTrimTrigger = 1'b1;
		repeat (3) @(posedge core_clk);
		check({9'h000, trimBusy}, 10'h001, "trim start");
		n = 0;
		while (trimBusy !== 1'b0 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		drive(10'h210, 10'h1f0, 1'b1, 1'b0);
		offsetTrimTrigger = 1'b0;
		pairs();
		check(capFirst, 10'h20b, "trimmed first");
		check(capSecond, 10'h1eb, "trimmed second");
	endtask
	task automatic power_test();
		int n;
		drive(10'h300, 10'h300, 1'b1, 1'b0);
		standbyRequest = 1'b1;
		repeat (5) @(posedge core_clk);
		check({9'h000, converting}, 10'h000, "standby");
		#1 standbyRequest = 1'b0;
		wake_time(n);
		check({9'h000, n <= 23}, 10'h001, "standby wake");
		#1 standbyRequest = 1'b1;
		deepSleepRequest = 1'b1;
		repeat (5) @(posedge core_clk);
		#1 standbyRequest = 1'b0;
		deepSleepRequest = 1'b0;
		wake_time(n);
		check({9'h000, n >= 45}, 10'h001, "sleep wins");
		check({9'h000, n <= 53}, 10'h001, "sleep wake");
		pairs();
		check(capFirst, 10'h2fb, "kept offset");
	endtask
	task automatic stop_test();
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge core_clk);
		#1 rst = 1'b0;
		parallel_test();
		mux_test();
		trim_test();
		power_test();
		stop_test();
	end
	initial begin
		#100us;
		fail_count++;
		stop_test();
	end
endmodule
